// ### wri_pkg.sv
// Package for the wake-up and reset register initialisation block.
// Assumes a single core clock domain and an 8-bit register file.
package wri_pkg;

  localparam int unsigned PC_W = 21;
  localparam int unsigned STK_W = 5;
  localparam logic [20:0] VEC_RESET = 21'h000000;
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW = 21'h000018;
  localparam logic [4:0] SP_RST = 5'h00;
  localparam int unsigned PA_HI_LSB = 6;
  localparam logic [7:0] PA_IMPL_LO = 8'h3F;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [7:0] PER_RST = 8'h00;
  localparam logic [7:0] PER_IMPL = 8'hFF;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    WRI_EV_NONE,
    WRI_EV_POR,
    WRI_EV_WARM,
    WRI_EV_WAKE
  } wri_event_t;

  typedef enum {
    WRI_RUN,
    WRI_SLEEP,
    WRI_VECTOR
  } wri_state_t;

endpackage

// ### wri_if.sv
// Interface carrying the port-A register group between the top and its mask unit.
// Assumes both ends share clk_in.
`timescale 1ns/10ps
interface wri_if;
  logic [7:0] dir_raw;
  logic [7:0] lat_raw;
  logic [7:0] pin_raw;
  logic osc_frees_hi;
  logic [7:0] dir_rd;
  logic [7:0] lat_rd;
  logic [7:0] pin_rd;
  modport core (output dir_raw, lat_raw, pin_raw, osc_frees_hi, input dir_rd, lat_rd, pin_rd);
  modport mask (input dir_raw, lat_raw, pin_raw, osc_frees_hi, output dir_rd, lat_rd, pin_rd);
endinterface

// ### wri_port_a_input_mask.sv
// Read masking of port-A bits 6 and 7 depending on the oscillator mode.
// Assumes raw register values come from the top module on the same clock.
`timescale 1ns/10ps
module wri_pa_mask (
  wri_if.mask pa
);

  function automatic logic [7:0] wri_hide(input logic [7:0] v, input logic freed);
    wri_hide = freed ? v : (v & wri_pkg::PA_IMPL_LO);
  endfunction

  always_comb
  begin
    pa.dir_rd = wri_hide(pa.dir_raw, pa.osc_frees_hi);
    pa.lat_rd = wri_hide(pa.lat_raw, pa.osc_frees_hi);
    pa.pin_rd = wri_hide(pa.pin_raw, pa.osc_frees_hi);
  end

endmodule

// ### wri_top.sv
// Core state and register initialisation for each kind of reset and wake-up.
// Assumes the reset cause, wake source and sleep request are one-cycle pulses from core logic.
// How it works
// - interrupt wake with enable loads vector
// - save program counter into stack top
// - advance hardware stack pointer on vectoring
// - wake-up always sets a source flag
// - port-A bits 6,7 hidden unless freed
// - unimplemented bits always read as zero
`timescale 1ns/10ps
module wri_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic por_in,
  input wire logic warm_reset_in,
  input wire logic sleep_in,
  input wire logic wake_wdt_in,
  input wire logic wake_irq_in,
  input wire logic wake_irq_high_in,
  input wire logic [7:0] wake_flags_in,
  input wire logic low_priority_global_int_enable_in,
  input wire logic high_priority_global_int_enable_in,
  input wire logic [20:0] pc_in,
  input wire logic osc_frees_hi_in,
  input wire logic [7:0] pins_in,
  input wire logic wr_en_in,
  input wire logic [2:0] wr_sel_in,
  input wire logic [7:0] wr_data_in,
  output logic [20:0] pc_out,
  output logic pc_load_out,
  output logic [7:0] stack_top_upper_byte_out,
  output logic [7:0] stack_top_high_byte_out,
  output logic [7:0] stack_top_low_byte_out,
  output logic [4:0] hw_stack_pointer_out,
  output logic [7:0] int_flags_out,
  output logic [7:0] port_a_input_out,
  output logic [7:0] port_a_output_latch_out,
  output logic [7:0] port_a_direction_out,
  output logic [7:0] periph_out,
  output logic sleeping_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: three stages, a change counts when stages two and three agree.
  logic [7:0] s1_q, s2_q, s3_q, pin_q;
  logic [7:0] pin_d;

  always_comb
  begin
    pin_d = pin_q;
    if (s2_q == s3_q)
    begin
      pin_d = s3_q;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s1_q <= wri_pkg::BYTE_ZERO;
      s2_q <= wri_pkg::BYTE_ZERO;
      s3_q <= wri_pkg::BYTE_ZERO;
      pin_q <= wri_pkg::BYTE_ZERO;
    end
    else
    begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event classification; power-on wins over warm reset, resets win over wake-up.
  wri_pkg::wri_event_t ev;
  wri_pkg::wri_state_t st_q, st_d;
  logic wake_any;

  assign wake_any = (wake_wdt_in | wake_irq_in) && (st_q == wri_pkg::WRI_SLEEP);

  always_comb
  begin
    if (por_in)
    begin
      ev = wri_pkg::WRI_EV_POR;
    end
    else if (warm_reset_in)
    begin
      ev = wri_pkg::WRI_EV_WARM;
    end
    else if (wake_any)
    begin
      ev = wri_pkg::WRI_EV_WAKE;
    end
    else
    begin
      ev = wri_pkg::WRI_EV_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register group state.
  logic [20:0] pc_q, pc_d;
  logic pcl_q, pcl_d, slp_q, slp_d;
  logic [7:0] stk_up_q, stk_up_d, stk_hi_q, stk_hi_d, stk_lo_q, stk_lo_d;
  logic [4:0] sp_q, sp_d;
  logic [7:0] flg_q, flg_d, dir_q, dir_d, lat_q, lat_d, per_q, per_d;
  logic vec_ok;

  assign vec_ok = wake_irq_in & (low_priority_global_int_enable_in | high_priority_global_int_enable_in);

  always_comb
  begin
    st_d = st_q;
    pc_d = pc_q;
    pcl_d = 1'b0;
    stk_up_d = stk_up_q;
    stk_hi_d = stk_hi_q;
    stk_lo_d = stk_lo_q;
    sp_d = sp_q;
    flg_d = flg_q;
    dir_d = dir_q;
    lat_d = lat_q;
    per_d = per_q;
    if (wr_en_in && ev == wri_pkg::WRI_EV_NONE)
    begin
      if (wr_sel_in == 3'h0)
      begin
        dir_d = wr_data_in;
      end
      else if (wr_sel_in == 3'h1)
      begin
        lat_d = wr_data_in;
      end
      else if (wr_sel_in == 3'h2)
      begin
        per_d = wr_data_in & wri_pkg::PER_IMPL;
      end
      else if (wr_sel_in == 3'h3)
      begin
        flg_d = wr_data_in;
      end
    end
    case (ev)
      wri_pkg::WRI_EV_POR:
      begin
        st_d = wri_pkg::WRI_RUN;
        pc_d = wri_pkg::VEC_RESET;
        pcl_d = 1'b1;
        stk_up_d = wri_pkg::BYTE_ZERO;
        stk_hi_d = wri_pkg::BYTE_ZERO;
        stk_lo_d = wri_pkg::BYTE_ZERO;
        sp_d = wri_pkg::SP_RST;
        flg_d = wri_pkg::FLAG_RST;
        dir_d = wri_pkg::DIR_RST;
        lat_d = wri_pkg::LAT_RST;
        per_d = wri_pkg::PER_RST;
      end
      wri_pkg::WRI_EV_WARM:
      begin
        st_d = wri_pkg::WRI_RUN;
        pc_d = wri_pkg::VEC_RESET;
        pcl_d = 1'b1;
        stk_up_d = wri_pkg::BYTE_ZERO;
        stk_hi_d = wri_pkg::BYTE_ZERO;
        stk_lo_d = wri_pkg::BYTE_ZERO;
        sp_d = wri_pkg::SP_RST;
        flg_d = wri_pkg::FLAG_RST;
        dir_d = wri_pkg::DIR_RST;
        per_d = wri_pkg::PER_RST;
      end
      wri_pkg::WRI_EV_WAKE:
      begin
        flg_d = flg_q | wake_flags_in | 8'h01;
        st_d = wri_pkg::WRI_RUN;
        if (vec_ok)
        begin
          st_d = wri_pkg::WRI_VECTOR;
          pc_d = wake_irq_high_in ? wri_pkg::VEC_HIGH : wri_pkg::VEC_LOW;
          pcl_d = 1'b1;
          stk_up_d = {3'h0, pc_in[20:16]};
          stk_hi_d = pc_in[15:8];
          stk_lo_d = pc_in[7:0];
          sp_d = 5'(sp_q + 5'h01);
        end
      end
      default:
      begin
        if (sleep_in)
        begin
          st_d = wri_pkg::WRI_SLEEP;
        end
        else if (st_q == wri_pkg::WRI_VECTOR)
        begin
          st_d = wri_pkg::WRI_RUN;
        end
      end
    endcase
    slp_d = (st_d == wri_pkg::WRI_SLEEP);
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_q <= wri_pkg::WRI_RUN;
      pc_q <= wri_pkg::VEC_RESET;
      pcl_q <= 1'b0;
      slp_q <= 1'b0;
      stk_up_q <= wri_pkg::BYTE_ZERO;
      stk_hi_q <= wri_pkg::BYTE_ZERO;
      stk_lo_q <= wri_pkg::BYTE_ZERO;
      sp_q <= wri_pkg::SP_RST;
      flg_q <= wri_pkg::FLAG_RST;
      dir_q <= wri_pkg::DIR_RST;
      lat_q <= wri_pkg::LAT_RST;
      per_q <= wri_pkg::PER_RST;
    end
    else
    begin
      st_q <= st_d;
      pc_q <= pc_d;
      pcl_q <= pcl_d;
      slp_q <= slp_d;
      stk_up_q <= stk_up_d;
      stk_hi_q <= stk_hi_d;
      stk_lo_q <= stk_lo_d;
      sp_q <= sp_d;
      flg_q <= flg_d;
      dir_q <= dir_d;
      lat_q <= lat_d;
      per_q <= per_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port-A read view; registered again so every output leaves a flip-flop.
  wri_if pa();
  logic [7:0] pa_in_q, pa_lat_q, pa_dir_q;

  assign pa.dir_raw = dir_q;
  assign pa.lat_raw = lat_q;
  assign pa.pin_raw = pin_q;
  assign pa.osc_frees_hi = osc_frees_hi_in;

  wri_pa_mask u_mask (
    .pa(pa)
  );

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pa_in_q <= wri_pkg::BYTE_ZERO;
      pa_lat_q <= wri_pkg::BYTE_ZERO;
      pa_dir_q <= wri_pkg::BYTE_ZERO;
    end
    else
    begin
      pa_in_q <= pa.pin_rd;
      pa_lat_q <= pa.lat_rd;
      pa_dir_q <= pa.dir_rd;
    end
  end

  assign pc_out = pc_q;
  assign pc_load_out = pcl_q;
  assign stack_top_upper_byte_out = stk_up_q;
  assign stack_top_high_byte_out = stk_hi_q;
  assign stack_top_low_byte_out = stk_lo_q;
  assign hw_stack_pointer_out = sp_q;
  assign int_flags_out = flg_q;
  assign port_a_input_out = pa_in_q;
  assign port_a_output_latch_out = pa_lat_q;
  assign port_a_direction_out = pa_dir_q;
  assign periph_out = per_q;
  assign sleeping_out = slp_q;

endmodule

// ### wri_top_monitor.sv
// Port assertions for wri_top.
// Assumes one clock domain; bound to every wri_top.
`timescale 1ns/10ps
module wri_top_monitor (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic por_in,
  input wire logic warm_reset_in,
  input wire logic wake_irq_in,
  input wire logic wake_irq_high_in,
  input wire logic [7:0] wake_flags_in,
  input wire logic low_priority_global_int_enable_in,
  input wire logic high_priority_global_int_enable_in,
  input wire logic [20:0] pc_in,
  input wire logic osc_frees_hi_in,
  input wire logic [20:0] pc_out,
  input wire logic pc_load_out,
  input wire logic [7:0] stack_top_upper_byte_out,
  input wire logic [7:0] stack_top_high_byte_out,
  input wire logic [7:0] stack_top_low_byte_out,
  input wire logic [4:0] hw_stack_pointer_out,
  input wire logic [7:0] int_flags_out,
  input wire logic [7:0] port_a_output_latch_out,
  input wire logic [7:0] port_a_direction_out,
  input wire logic sleeping_out
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////
  sequence irq_wake;
    wake_irq_in && sleeping_out && !por_in && !warm_reset_in;
  endsequence
  sequence vec_wake;
    irq_wake ##0 (low_priority_global_int_enable_in || high_priority_global_int_enable_in);
  endsequence
  a_vector_load: assert property (
    vec_wake |=> pc_load_out && pc_out == ($past(wake_irq_high_in) ? wri_pkg::VEC_HIGH : wri_pkg::VEC_LOW))
    else $error("bad vector");
  a_stack_save: assert property (
    vec_wake |=> {stack_top_upper_byte_out[4:0], stack_top_high_byte_out, stack_top_low_byte_out} == $past(pc_in))
    else $error("bad stack top");
  a_sp_advance: assert property (
    vec_wake |=> hw_stack_pointer_out == $past(hw_stack_pointer_out) + 5'h01)
    else $error("bad stack pointer");
  a_wake_flag: assert property (
    irq_wake |=> int_flags_out[0] && (int_flags_out & $past(wake_flags_in)) == $past(wake_flags_in))
    else $error("no wake flag");
  // The masked outputs lag the mode input by one cycle, so the mode must be settled first.
  a_pa_hidden: assert property (
    !osc_frees_hi_in && !$past(osc_frees_hi_in) && !$past(osc_frees_hi_in, 2)
    |-> (port_a_output_latch_out | port_a_direction_out) < 8'h40)
    else $error("port bit 6 or 7 visible");
  a_unimpl_zero: assert property (
    stack_top_upper_byte_out[7:5] == 3'h0)
    else $error("unused bits set");
  a_por_defaults: assert property (
    por_in |=> int_flags_out == wri_pkg::FLAG_RST ##1 port_a_output_latch_out == wri_pkg::LAT_RST)
    else $error("bad power-on values");
endmodule
bind wri_top wri_top_monitor mon_u (.*);

// ### testbench.sv
// Bench for wri_top with a small reference model.
// Assumes the checker binds itself; inputs change on the falling edge.
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'h0, reset_n_in = 1'h0, por_in = 1'h0, warm_reset_in = 1'h0, sleep_in = 1'h0;
  logic wake_wdt_in = 1'h0, wake_irq_in = 1'h0, wake_irq_high_in = 1'h0, osc_frees_hi_in = 1'h1, wr_en_in = 1'h0;
  logic low_priority_global_int_enable_in = 1'h0, high_priority_global_int_enable_in = 1'h0;
  logic [7:0] wake_flags_in = 8'h00, pins_in = 8'h00, wr_data_in = 8'h00;
  logic [2:0] wr_sel_in = 3'h0;
  logic [20:0] pc_in = 21'h000000, pc_out;
  logic pc_load_out, sleeping_out;
  logic [7:0] stack_top_upper_byte_out, stack_top_high_byte_out, stack_top_low_byte_out, int_flags_out;
  logic [7:0] port_a_input_out, port_a_output_latch_out, port_a_direction_out, periph_out;
  logic [4:0] hw_stack_pointer_out;
  int n_mismatch, checks_done, e_dir = 32'hFF, e_lat, e_per, e_flg, e_sp, e_pc, e_tos;
  wri_top dut_u (.*);
  always #20 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Two falling edges let port-A outputs settle after the pulse.
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge clk_in);
    s = 1'h0;
    if (wr_en_in)
      wr_en_in = 1'h0;
    @(negedge clk_in);
  endtask
  task wr(input logic [2:0] sel, input logic [7:0] d);
    wr_sel_in = sel;
    wr_data_in = d;
    pulse(wr_en_in);
    case (sel)
      3'h0: e_dir = d;
      3'h1: e_lat = d;
      3'h2: e_per = d;
      default: e_flg = d;
    endcase
  endtask
  task check_all();
    logic [7:0] m;
    m = osc_frees_hi_in ? 8'hFF : 8'h3F;
    chk(periph_out, e_per);
    chk(int_flags_out, e_flg);
    chk(sleeping_out, 1'h0);
    chk(hw_stack_pointer_out, e_sp);
    chk(pc_out, e_pc);
    chk(pc_load_out, 1'h0);
    chk({stack_top_upper_byte_out, stack_top_high_byte_out, stack_top_low_byte_out}, e_tos);
    chk(port_a_output_latch_out, e_lat & m);
    chk(port_a_direction_out, e_dir & m);
    chk(port_a_input_out, pins_in & m);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h806F));
    pins_in = 8'($urandom);
    repeat (10) @(negedge clk_in);
    reset_n_in = 1'h1;
    repeat (6) @(negedge clk_in);
    check_all();
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      osc_frees_hi_in = !i[2];
      wr(3'(i % 4), 8'($urandom));
      check_all();
    end
    $display("write test done");
    for (int k = 0; k < 6; k++)
    begin
      high_priority_global_int_enable_in = k[0] | k[2];
      low_priority_global_int_enable_in = k[1];
      wake_irq_high_in = 1'($urandom);
      wake_flags_in = 8'($urandom);
      pc_in = 21'($urandom);
      if (k != 4)
        pulse(sleep_in);
      chk(sleeping_out, k != 4);
      if (k == 5)
        pulse(wake_wdt_in);
      else
        pulse(wake_irq_in);
      if (k != 4)
        e_flg = e_flg | wake_flags_in | 32'h1;
      if (k > 0 && k < 4)
      begin
        e_pc = wake_irq_high_in ? 32'h8 : 32'h18;
        e_tos = pc_in;
        e_sp = (e_sp + 1) % 32;
      end
      check_all();
    end
    $display("wake test done");
    wr_sel_in = 3'h2;
    wr_data_in = 8'h5A;
    wr_en_in = 1'h1;
    pulse(warm_reset_in);
    e_dir = 32'hFF;
    e_per = 0;
    e_flg = 0;
    e_sp = 0;
    e_pc = 0;
    e_tos = 0;
    check_all();
    osc_frees_hi_in = 1'h1;
    pulse(por_in);
    e_lat = 0;
    check_all();
    $display("reset kinds test done");
    give_verdict();
  end
  initial
  begin
    #100us;
    n_mismatch++;
    give_verdict();
  end
endmodule
